// ### logic/crf_pkg.sv
// shared constants and types for the cpu register file
package crf_pkg;
   localparam int WORD_W = 16;
   localparam int BYTE_W = 8;
   localparam int BANK_W = 8;
   localparam int ADDR_W = 24;
   localparam logic [15:0] RESET_WORD = 16'h0000;
   localparam logic [23:0] RESET_ADDR = 24'h000000;
   localparam logic WIDTH_FULL = 1'b0;
   localparam logic WIDTH_BYTE = 1'b1;
   localparam int READ_LATENCY = 1;
   localparam int ADDR_LATENCY = 1;

   typedef enum logic [2:0] {
      CRF_SEL_ACC_A,
      CRF_SEL_ACC_B,
      CRF_SEL_IDX_X,
      CRF_SEL_IDX_Y,
      CRF_SEL_STACK,
      CRF_SEL_NONE
   } crf_sel_e;

   typedef enum logic [1:0] {
      CRF_IDX_NONE,
      CRF_IDX_X,
      CRF_IDX_Y
   } crf_idx_e;
endpackage : crf_pkg

// ### logic/crf_addr_gen.sv
// effective address adder for indexed addressing
`timescale 1ns/1ps
module crf_addr_gen (
   // index selection
   input wire crf_pkg::crf_idx_e idx_mode,
   input wire logic [15:0] idx_x,
   input wire logic [15:0] idx_y,
   // address
   input wire logic [23:0] base_addr,
   output logic [23:0] eff_addr
);
   logic [15:0] idx_val;

   always_comb begin
      case (idx_mode)
         crf_pkg::CRF_IDX_X: idx_val = idx_x;
         crf_pkg::CRF_IDX_Y: idx_val = idx_y;
         default: idx_val = 16'h0000;
      endcase
      // carry out of the low 16 bits ripples into the bank byte
      eff_addr = base_addr + {8'h00, idx_val};
   end
endmodule : crf_addr_gen

// ### logic/crf_regfile.sv
// working register file: accumulators, index registers and stack pointer
//
// Contract
// - The core has ten programmer registers and this block holds the two accumulators, two index registers and the stack pointer.
// - The primary accumulator is 16 bits wide and its low byte is usable alone as a byte register.
// - The primary accumulator works at 16 bits when the data width flag is 0 and at 8 bits when it is 1.
// - The primary accumulator is the main operand and result path for arithmetic, transfer and input/output.
// - The secondary accumulator has the same width control and function as the primary one.
// - The first index register is 16 bits with a usable low byte, full width when the index flag is 0, byte when it is 1; block moves still use all 16 bits.
// - Indexed modes using the first index register add it to the base address to give the effective address.
// - Block moves take the source address low 16 bits from the first index register and the high byte from opcode byte three.
// - The second index register is 16 bits with a usable low byte and follows the same index width flag; block moves still use all 16 bits.
// - Indexed modes using the second index register add it to the base address to give the effective address.
// - Block moves take the destination address low 16 bits from the second index register and the high byte from byte two.
// - The stack pointer is a 16-bit register used by calls, interrupts and stack-based addressing.
`timescale 1ns/1ps
module crf_regfile (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // width flags from the processor_status_word
   input wire logic data_len_flag,
   input wire logic index_len_flag,
   // write port
   input wire logic wr_en,
   input wire crf_pkg::crf_sel_e wr_sel,
   input wire logic [15:0] wr_data,
   // read port
   input wire crf_pkg::crf_sel_e rd_sel,
   output logic [15:0] rd_data,
   // operand paths to the alu
   output logic [15:0] acc_a,
   output logic [15:0] acc_b,
   output logic [15:0] stack_ptr,
   // indexed addressing
   input wire logic idx_req,
   input wire crf_pkg::crf_idx_e idx_mode,
   input wire logic [23:0] base_addr,
   output logic [23:0] eff_addr,
   output logic eff_valid,
   // block_move_first_form / block_move_second_form
   input wire logic blk_req,
   input wire logic [7:0] blk_src_bank,
   input wire logic [7:0] blk_dst_bank,
   output logic [23:0] blk_src_addr,
   output logic [23:0] blk_dst_addr,
   output logic blk_valid
);
   typedef struct packed {
      logic [15:0] a;
      logic [15:0] b;
      logic [15:0] x;
      logic [15:0] y;
      logic [15:0] sp;
      logic [15:0] rd_data;
      logic [23:0] eff_addr;
      logic eff_valid;
      logic [23:0] src_addr;
      logic [23:0] dst_addr;
      logic blk_valid;
   } crf_state_s;

   crf_state_s state;
   crf_state_s next_state;
   logic [23:0] sum_addr;
   logic [15:0] idx_x_eff;
   logic [15:0] idx_y_eff;

   // byte mode shows only the low byte; upper reads as zero
   function automatic logic [15:0] crf_view(input logic [15:0] val, input logic byte_mode);
      crf_view = byte_mode ? {8'h00, val[7:0]} : val;
   endfunction : crf_view

   // byte mode writes merge into the low byte only
   function automatic logic [15:0] crf_merge(input logic [15:0] old, input logic [15:0] din,
                                             input logic byte_mode);
      crf_merge = byte_mode ? {old[15:8], din[7:0]} : din;
   endfunction : crf_merge

   // index registers at byte width add only their low byte
   assign idx_x_eff = crf_view(state.x, index_len_flag);
   assign idx_y_eff = crf_view(state.y, index_len_flag);

   crf_addr_gen u_addr_gen (
      .idx_mode(idx_mode),
      .idx_x(idx_x_eff),
      .idx_y(idx_y_eff),
      .base_addr(base_addr),
      .eff_addr(sum_addr)
   );

   always_comb begin
      next_state = state;
      next_state.eff_valid = 1'b0;
      next_state.blk_valid = 1'b0;
      if (wr_en) begin
         case (wr_sel)
            crf_pkg::CRF_SEL_ACC_A: next_state.a = crf_merge(state.a, wr_data, data_len_flag);
            crf_pkg::CRF_SEL_ACC_B: next_state.b = crf_merge(state.b, wr_data, data_len_flag);
            crf_pkg::CRF_SEL_IDX_X: next_state.x = crf_merge(state.x, wr_data, index_len_flag);
            crf_pkg::CRF_SEL_IDX_Y: next_state.y = crf_merge(state.y, wr_data, index_len_flag);
            crf_pkg::CRF_SEL_STACK: next_state.sp = wr_data;
            default: next_state.sp = state.sp;
         endcase
      end
      // reads see the old value when a write hits the same register
      case (rd_sel)
         crf_pkg::CRF_SEL_ACC_A: next_state.rd_data = crf_view(state.a, data_len_flag);
         crf_pkg::CRF_SEL_ACC_B: next_state.rd_data = crf_view(state.b, data_len_flag);
         crf_pkg::CRF_SEL_IDX_X: next_state.rd_data = crf_view(state.x, index_len_flag);
         crf_pkg::CRF_SEL_IDX_Y: next_state.rd_data = crf_view(state.y, index_len_flag);
         crf_pkg::CRF_SEL_STACK: next_state.rd_data = state.sp;
         default: next_state.rd_data = crf_pkg::RESET_WORD;
      endcase
      if (idx_req) begin
         next_state.eff_addr = sum_addr;
         next_state.eff_valid = 1'b1;
      end
      if (blk_req) begin
         // both move forms take the same address sources
         next_state.src_addr = {blk_src_bank, state.x};
         next_state.dst_addr = {blk_dst_bank, state.y};
         next_state.blk_valid = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         // five of the ten core registers live here
         state.a <= crf_pkg::RESET_WORD;
         state.b <= crf_pkg::RESET_WORD;
         state.x <= crf_pkg::RESET_WORD;
         state.y <= crf_pkg::RESET_WORD;
         state.sp <= crf_pkg::RESET_WORD;
         state.rd_data <= crf_pkg::RESET_WORD;
         state.eff_addr <= crf_pkg::RESET_ADDR;
         state.eff_valid <= 1'b0;
         state.src_addr <= crf_pkg::RESET_ADDR;
         state.dst_addr <= crf_pkg::RESET_ADDR;
         state.blk_valid <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   assign rd_data = state.rd_data;
   assign acc_a = state.a;
   assign acc_b = state.b;
   assign stack_ptr = state.sp;
   assign eff_addr = state.eff_addr;
   assign eff_valid = state.eff_valid;
   assign blk_src_addr = state.src_addr;
   assign blk_dst_addr = state.dst_addr;
   assign blk_valid = state.blk_valid;

   // checks

   sequence s_wr_a_full;
      wr_en && wr_sel == crf_pkg::CRF_SEL_ACC_A && data_len_flag == crf_pkg::WIDTH_FULL;
   endsequence

   sequence s_wr_a_byte;
      wr_en && wr_sel == crf_pkg::CRF_SEL_ACC_A && data_len_flag == crf_pkg::WIDTH_BYTE;
   endsequence

   sequence s_wr_b_byte;
      wr_en && wr_sel == crf_pkg::CRF_SEL_ACC_B && data_len_flag == crf_pkg::WIDTH_BYTE;
   endsequence

   sequence s_wr_x_any;
      wr_en && wr_sel == crf_pkg::CRF_SEL_IDX_X;
   endsequence

   sequence s_wr_y_byte;
      wr_en && wr_sel == crf_pkg::CRF_SEL_IDX_Y && index_len_flag == crf_pkg::WIDTH_BYTE;
   endsequence

   sequence s_wr_b_full;
      wr_en && wr_sel == crf_pkg::CRF_SEL_ACC_B && data_len_flag == crf_pkg::WIDTH_FULL;
   endsequence

   sequence s_wr_x_byte;
      wr_en && wr_sel == crf_pkg::CRF_SEL_IDX_X && index_len_flag == crf_pkg::WIDTH_BYTE;
   endsequence

   sequence s_wr_y_full;
      wr_en && wr_sel == crf_pkg::CRF_SEL_IDX_Y && index_len_flag == crf_pkg::WIDTH_FULL;
   endsequence

   sequence s_idx_x_req;
      idx_req && idx_mode == crf_pkg::CRF_IDX_X;
   endsequence

   sequence s_idx_y_req;
      idx_req && idx_mode == crf_pkg::CRF_IDX_Y;
   endsequence

   a_acc_a_full: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_wr_a_full |=> acc_a == $past(wr_data))
      else $error("acc a full write lost");

   a_acc_a_byte: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_wr_a_byte |=> acc_a == {$past(acc_a[15:8]), $past(wr_data[7:0])})
      else $error("acc a byte write touched upper byte");

   a_acc_b_byte: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_wr_b_byte |=> acc_b[15:8] == $past(acc_b[15:8]) && acc_b[7:0] == $past(wr_data[7:0]))
      else $error("acc b byte write wrong");

   a_idx_x_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_wr_x_any ##1 (rd_sel == crf_pkg::CRF_SEL_IDX_X && index_len_flag == $past(index_len_flag))
      |=> rd_data == ($past(index_len_flag, 2) ? {8'h00, $past(wr_data[7:0], 2)} : $past(wr_data, 2)))
      else $error("index x write then read mismatch");

   a_idx_y_byte: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_wr_y_byte ##1 (rd_sel == crf_pkg::CRF_SEL_IDX_Y)
      |=> rd_data[7:0] == $past(wr_data[7:0], 2)
          && rd_data[15:8] == ($past(index_len_flag) ? 8'h00 : $past(state.y[15:8], 2)))
      else $error("index y byte write wrong");

   a_eff_x_sum: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_idx_x_req |=> eff_valid && eff_addr == $past(base_addr) + {8'h00, $past(idx_x_eff)})
      else $error("indexed x address wrong");

   a_eff_y_sum: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_idx_y_req |=> eff_valid && eff_addr == $past(base_addr) + {8'h00, $past(idx_y_eff)})
      else $error("indexed y address wrong");

   a_eff_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !idx_req |=> !eff_valid)
      else $error("address valid without request");

   a_blk_source: assert property (@(posedge sys_clk) disable iff (!rst_n)
      blk_req |=> blk_valid && blk_src_addr == {$past(blk_src_bank), $past(state.x)})
      else $error("block source address wrong");

   a_blk_dest: assert property (@(posedge sys_clk) disable iff (!rst_n)
      blk_req |=> blk_dst_addr == {$past(blk_dst_bank), $past(state.y)})
      else $error("block destination address wrong");

   a_stack_full: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (wr_en && wr_sel == crf_pkg::CRF_SEL_STACK && data_len_flag == crf_pkg::WIDTH_BYTE)
      |=> stack_ptr == $past(wr_data))
      else $error("stack pointer not full width");

   a_read_acc_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (rd_sel == crf_pkg::CRF_SEL_ACC_A && data_len_flag == crf_pkg::WIDTH_BYTE)
      |=> rd_data == {8'h00, $past(acc_a[7:0])})
      else $error("byte read of acc a wrong");

   a_hold_others: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (wr_en && wr_sel == crf_pkg::CRF_SEL_STACK) |=> acc_a == $past(acc_a) && acc_b == $past(acc_b))
      else $error("stack write disturbed accumulators");

   // byte-mode index writes keep the upper byte for a later full-width view
   a_idx_x_byte: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_wr_x_byte |=> state.x == {$past(state.x[15:8]), $past(wr_data[7:0])})
      else $error("index x byte write touched upper byte");

   a_acc_b_full: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_wr_b_full |=> acc_b == $past(wr_data))
      else $error("acc b full write lost");

   a_idx_y_full: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_wr_y_full |=> state.y == $past(wr_data))
      else $error("index y full write lost");

   a_read_acc_b: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (rd_sel == crf_pkg::CRF_SEL_ACC_B && data_len_flag == crf_pkg::WIDTH_BYTE)
      |=> rd_data == {8'h00, $past(acc_b[7:0])})
      else $error("byte read of acc b wrong");

   a_read_y_byte: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (rd_sel == crf_pkg::CRF_SEL_IDX_Y && index_len_flag == crf_pkg::WIDTH_BYTE) |=> rd_data[15:8] == 8'h00)
      else $error("byte read of index y shows upper byte");

   a_read_stack: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rd_sel == crf_pkg::CRF_SEL_STACK |=> rd_data == $past(stack_ptr))
      else $error("stack pointer read wrong");

   a_read_none: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rd_sel == crf_pkg::CRF_SEL_NONE |=> rd_data == crf_pkg::RESET_WORD)
      else $error("read of no register not zero");

   a_eff_none: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (idx_req && idx_mode == crf_pkg::CRF_IDX_NONE) |=> eff_addr == $past(base_addr))
      else $error("unindexed address not the base");

   // results hold between requests so a slow consumer can still pick them up
   a_eff_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !idx_req |=> $stable(eff_addr))
      else $error("effective address moved without request");

   a_blk_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !blk_req |=> !blk_valid)
      else $error("block valid without request");

   a_blk_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !blk_req |=> $stable(blk_src_addr) && $stable(blk_dst_addr))
      else $error("block addresses moved without request");

   a_none_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (wr_en && wr_sel == crf_pkg::CRF_SEL_NONE)
      |=> $stable(acc_a) && $stable(acc_b) && $stable(stack_ptr))
      else $error("write to no register changed state");
endmodule : crf_regfile

// ### test/test_cpu_register_file.sv
// self-checking testbench for the cpu register file
`timescale 1ns/1ps
module test_cpu_register_file;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic data_len_flag = 1'b0;
   logic index_len_flag = 1'b0;
   logic wr_en = 1'b0;
   crf_pkg::crf_sel_e wr_sel = crf_pkg::CRF_SEL_NONE;
   logic [15:0] wr_data = 16'h0000;
   crf_pkg::crf_sel_e rd_sel = crf_pkg::CRF_SEL_NONE;
   logic [15:0] rd_data, acc_a, acc_b, stack_ptr;
   logic idx_req = 1'b0;
   crf_pkg::crf_idx_e idx_mode = crf_pkg::CRF_IDX_NONE;
   logic [23:0] base_addr = 24'h000000;
   logic [23:0] eff_addr, blk_src_addr, blk_dst_addr;
   logic eff_valid, blk_valid;
   logic blk_req = 1'b0;
   logic [7:0] blk_src_bank = 8'h00;
   logic [7:0] blk_dst_bank = 8'h00;
   int bad_count = 0;
   int n_checks = 0;
   int cycles = 0;

   crf_regfile u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .data_len_flag(data_len_flag),
      .index_len_flag(index_len_flag), .wr_en(wr_en), .wr_sel(wr_sel), .wr_data(wr_data),
      .rd_sel(rd_sel), .rd_data(rd_data), .acc_a(acc_a), .acc_b(acc_b), .stack_ptr(stack_ptr),
      .idx_req(idx_req), .idx_mode(idx_mode), .base_addr(base_addr), .eff_addr(eff_addr),
      .eff_valid(eff_valid), .blk_req(blk_req), .blk_src_bank(blk_src_bank),
      .blk_dst_bank(blk_dst_bank), .blk_src_addr(blk_src_addr), .blk_dst_addr(blk_dst_addr),
      .blk_valid(blk_valid));

   initial begin
      forever #5 sys_clk = ~sys_clk;
   end

   task results;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : results

   // hang guard: the whole run needs well under two hundred cycles
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         bad_count = bad_count + 1;
         results();
      end
   end

   task chk_val(input logic [23:0] got, input logic [23:0] exp);
      n_checks = n_checks + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_val

   task chk_bit(input logic got, input logic exp);
      n_checks = n_checks + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_bit

   // write is taken at the second edge; outputs are looked at just after it
   task wr(input crf_pkg::crf_sel_e sel, input logic [15:0] d, input logic m, input logic x);
      @(posedge sys_clk);
      wr_en <= 1'b1;
      wr_sel <= sel;
      wr_data <= d;
      data_len_flag <= m;
      index_len_flag <= x;
      @(posedge sys_clk);
      wr_en <= 1'b0;
      #1;
   endtask : wr

   task rd(input crf_pkg::crf_sel_e sel, input logic m, input logic x, input logic [15:0] exp);
      @(posedge sys_clk);
      rd_sel <= sel;
      data_len_flag <= m;
      index_len_flag <= x;
      @(posedge sys_clk);
      #1;
      chk_val({8'h00, rd_data}, {8'h00, exp});
   endtask : rd

   task idx(input crf_pkg::crf_idx_e mode, input logic [23:0] base, input logic x, input logic [23:0] exp);
      @(posedge sys_clk);
      idx_req <= 1'b1;
      idx_mode <= mode;
      base_addr <= base;
      index_len_flag <= x;
      @(posedge sys_clk);
      idx_req <= 1'b0;
      #1;
      chk_bit(eff_valid, 1'b1);
      chk_val(eff_addr, exp);
      @(posedge sys_clk);
      #1;
      chk_bit(eff_valid, 1'b0);
   endtask : idx

   task test_reset;
      chk_val({8'h00, acc_a}, 24'h000000);
      chk_val({8'h00, acc_b}, 24'h000000);
      chk_val({8'h00, stack_ptr}, 24'h000000);
      chk_bit(eff_valid, 1'b0);
      chk_bit(blk_valid, 1'b0);
   endtask : test_reset

   // a second reset in mid-run must clear the accumulators, stack pointer, read data and address outputs again
   task test_reset_mid;
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      #1;
      chk_val({8'h00, acc_a}, 24'h000000);
      chk_val({8'h00, acc_b}, 24'h000000);
      chk_val({8'h00, stack_ptr}, 24'h000000);
      chk_val({8'h00, rd_data}, 24'h000000);
      chk_val(eff_addr, 24'h000000);
      chk_val(blk_src_addr, 24'h000000);
      chk_val(blk_dst_addr, 24'h000000);
   endtask : test_reset_mid

   task test_acc;
      wr(crf_pkg::CRF_SEL_ACC_A, 16'h1234, 1'b0, 1'b0);
      chk_val({8'h00, acc_a}, 24'h001234);
      wr(crf_pkg::CRF_SEL_ACC_A, 16'habcd, 1'b1, 1'b0);
      chk_val({8'h00, acc_a}, 24'h0012cd);
      rd(crf_pkg::CRF_SEL_ACC_A, 1'b1, 1'b0, 16'h00cd);
      rd(crf_pkg::CRF_SEL_ACC_A, 1'b0, 1'b1, 16'h12cd);
      wr(crf_pkg::CRF_SEL_ACC_B, 16'h5678, 1'b0, 1'b1);
      wr(crf_pkg::CRF_SEL_ACC_B, 16'h9a0f, 1'b1, 1'b0);
      chk_val({8'h00, acc_b}, 24'h00560f);
      chk_val({8'h00, acc_a}, 24'h0012cd);
      rd(crf_pkg::CRF_SEL_ACC_B, 1'b1, 1'b0, 16'h000f);
   endtask : test_acc

   task test_stack;
      wr(crf_pkg::CRF_SEL_STACK, 16'hfedc, 1'b1, 1'b1);
      chk_val({8'h00, stack_ptr}, 24'h00fedc);
      wr(crf_pkg::CRF_SEL_NONE, 16'h1111, 1'b0, 1'b0);
      chk_val({acc_a, 8'h00}, 24'h12cd00);
      chk_val({acc_b, stack_ptr[7:0]}, 24'h560fdc);
      rd(crf_pkg::CRF_SEL_STACK, 1'b1, 1'b1, 16'hfedc);
   endtask : test_stack

   // index width follows the index flag only, never the data flag
   task test_index;
      wr(crf_pkg::CRF_SEL_IDX_X, 16'h8005, 1'b1, 1'b0);
      rd(crf_pkg::CRF_SEL_IDX_X, 1'b1, 1'b0, 16'h8005);
      wr(crf_pkg::CRF_SEL_IDX_X, 16'h33f0, 1'b0, 1'b1);
      rd(crf_pkg::CRF_SEL_IDX_X, 1'b0, 1'b0, 16'h80f0);
      rd(crf_pkg::CRF_SEL_IDX_X, 1'b0, 1'b1, 16'h00f0);
      wr(crf_pkg::CRF_SEL_IDX_Y, 16'hffff, 1'b1, 1'b0);
      rd(crf_pkg::CRF_SEL_IDX_Y, 1'b0, 1'b0, 16'hffff);
      rd(crf_pkg::CRF_SEL_IDX_Y, 1'b0, 1'b1, 16'h00ff);
      wr(crf_pkg::CRF_SEL_IDX_Y, 16'h1234, 1'b0, 1'b1);
      rd(crf_pkg::CRF_SEL_IDX_Y, 1'b0, 1'b0, 16'hff34);
      wr(crf_pkg::CRF_SEL_IDX_Y, 16'hffff, 1'b0, 1'b0);
      rd(crf_pkg::CRF_SEL_IDX_Y, 1'b0, 1'b0, 16'hffff);
   endtask : test_index

   task test_indexed;
      idx(crf_pkg::CRF_IDX_X, 24'h010000, 1'b0, 24'h0180f0);
      idx(crf_pkg::CRF_IDX_X, 24'h010000, 1'b1, 24'h0100f0);
      idx(crf_pkg::CRF_IDX_Y, 24'hfffff0, 1'b0, 24'h00ffef);
      idx(crf_pkg::CRF_IDX_Y, 24'h010000, 1'b1, 24'h0100ff);
      idx(crf_pkg::CRF_IDX_NONE, 24'h123456, 1'b0, 24'h123456);
   endtask : test_indexed

   // byte index mode must not trim the block move addresses
   task test_block;
      @(posedge sys_clk);
      blk_req <= 1'b1;
      blk_src_bank <= 8'h12;
      blk_dst_bank <= 8'h34;
      index_len_flag <= 1'b1;
      @(posedge sys_clk);
      blk_req <= 1'b0;
      #1;
      chk_bit(blk_valid, 1'b1);
      chk_val(blk_src_addr, 24'h1280f0);
      chk_val(blk_dst_addr, 24'h34ffff);
      @(posedge sys_clk);
      #1;
      chk_bit(blk_valid, 1'b0);
   endtask : test_block

   initial begin
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      #1;
      test_reset();
      test_acc();
      test_stack();
      test_index();
      test_indexed();
      test_block();
      test_reset_mid();
      results();
   end
endmodule : test_cpu_register_file
